// ---- core/contact_input_pkg.sv ----
// shared constants and register map for the contact input debounce block
package contact_input_pkg;
    localparam int NUM_INPUTS = 8;
    localparam int NUM_GROUPS = NUM_INPUTS / 4;
    localparam int CLK_HZ = 200000000;
    localparam int SCAN_PERIOD_US = 500;
    localparam int SCAN_CYCLES = (CLK_HZ / 1000000) * SCAN_PERIOD_US;
    localparam int US_CYCLES = CLK_HZ / 1000000;
    localparam int PASSES_PER_CYCLE = 8;
    localparam logic [7:0] DEFAULT_THRESHOLD = 8'h11;
    localparam logic [3:0] DEFAULT_DEBOUNCE = 4'h5;
    localparam logic [31:0] DEFAULT_PASS_CYCLES = 32'h00066BCB;
    // register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_LEVEL = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h0C;
    localparam logic [7:0] REG_THRESH = 8'h10;
    localparam logic [7:0] REG_PASS = 8'h14;
    localparam logic [7:0] REG_EVENT = 8'h18;
    localparam logic [7:0] REG_STAMP = 8'h1C;
    // config field positions
    localparam int CFG_DEBOUNCE_LSB = 0;
    localparam int CFG_ENABLE_LSB = 8;
    // status bit positions
    localparam int ST_EVENT = 0;
    localparam int ST_PASS = 1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ---- core/contact_debounce_lane.sv ----
// one contact input debounce lane with first-sample time capture
`timescale 1ns/1ps
module contact_debounce_lane
    import contact_input_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // scan interface
    input wire logic scan_tick_in,
    input wire logic sample_in,
    input wire logic [3:0] debounce_in,
    input wire logic [31:0] time_us_in,
    // results
    output logic state_out,
    output logic change_out,
    output logic [31:0] stamp_out
);
    typedef struct packed {
        logic state;
        logic change;
        logic [3:0] count;
        logic [31:0] first_stamp;
        logic [31:0] stamp;
    } lane_type;

    lane_type s_q;
    lane_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.change = 1'b0;
        if (scan_tick_in)
        begin
            if (sample_in == s_q.state)
            begin
                s_d.count = 4'h0;
            end
            else
            begin
                if (s_q.count == 4'h0)
                begin
                    s_d.first_stamp = time_us_in;
                end
                // debounce setting counts in scans; setting N accepts on sample N+1
                if (s_q.count >= debounce_in)
                begin
                    s_d.state = sample_in;
                    s_d.change = 1'b1;
                    s_d.count = 4'h0;
                    s_d.stamp = (s_q.count == 4'h0) ? time_us_in : s_q.first_stamp;
                end
                else
                begin
                    s_d.count = s_q.count + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign state_out = s_q.state;
    assign change_out = s_q.change;
    assign stamp_out = s_q.stamp;
endmodule

// ---- core/contact_input_debounce.sv ----
// contact input debounce top with scan timer, pass timer and axi4-lite registers
//
// Summary of operation
// - sample all inputs together every 0.5 ms
// - closed when level reaches group threshold
// - accept level after persisting debounce duration
// - stamp event with first new-level sample
// - publish closed operand and complementary open
// - per-input enable gates event records
// - refresh operands at start of pass
// - eight passes per cycle, frequency-tracked period
// - same debounce for both transition directions
// - delay equals debounce plus up to one pass
`timescale 1ns/1ps
module contact_input_debounce
    import contact_input_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // sensed contact voltages, 8-bit codes per input
    input wire logic [NUM_INPUTS*8-1:0] level_in,
    // protection pass side
    output logic pass_start_out,
    output logic [NUM_INPUTS-1:0] input_closed_operand_out,
    output logic [NUM_INPUTS-1:0] input_open_operand_out,
    // event record stream
    output logic event_valid_out,
    output logic [7:0] event_index_out,
    output logic event_state_out,
    output logic [31:0] event_stamp_out,
    // interrupt
    output logic irq_out,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    typedef struct packed {
        logic [NUM_INPUTS*8-1:0] sync1;
        logic [NUM_INPUTS*8-1:0] sync2;
        logic [16:0] scan_cnt;
        logic scan_tick;
        logic [7:0] us_cnt;
        logic [31:0] time_us;
        logic [31:0] pass_cnt;
        logic pass_start;
        logic [NUM_INPUTS-1:0] pending;
        logic [NUM_INPUTS-1:0] closed_op;
        logic [NUM_INPUTS-1:0] open_op;
        logic ev_valid;
        logic [7:0] ev_index;
        logic ev_state;
        logic [31:0] ev_stamp;
        logic [31:0] last_stamp;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic [3:0] debounce;
        logic [NUM_INPUTS-1:0] ev_enable;
        logic [NUM_GROUPS*8-1:0] thresh;
        logic [31:0] pass_cycles;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } top_type;

    top_type s_q;
    top_type s_d;

    logic [NUM_INPUTS-1:0] closed_sample;
    logic [NUM_INPUTS-1:0] lane_state;
    logic [NUM_INPUTS-1:0] lane_change;
    logic [31:0] lane_stamp [NUM_INPUTS];

    // ------------------------------------------------------------
    // threshold compare and debounce lanes
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_INPUTS; gi++)
        begin : g_lane
            // one threshold byte per group of four inputs
            assign closed_sample[gi] =
                s_q.sync2[gi*8 +: 8] >= s_q.thresh[(gi/4)*8 +: 8];
            contact_debounce_lane u_lane (
                .ref_clk_in(ref_clk_in),
                .reset_n_in(reset_n_in),
                .scan_tick_in(s_q.scan_tick),
                .sample_in(closed_sample[gi]),
                .debounce_in(s_q.debounce),
                .time_us_in(s_q.time_us),
                .state_out(lane_state[gi]),
                .change_out(lane_change[gi]),
                .stamp_out(lane_stamp[gi])
            );
        end
    endgenerate

    always_comb
    begin
        logic [31:0] wmerged;
        logic [31:0] cur;
        logic found;
        logic do_write;
        wmerged = 32'h0;
        cur = 32'h0;
        found = 1'b0;
        do_write = 1'b0;
        s_d = s_q;

        // ------------------------------------------------------------
        // synchronisers and time base
        // ------------------------------------------------------------
        s_d.sync1 = level_in;
        s_d.sync2 = s_q.sync1;
        s_d.scan_tick = 1'b0;
        // the scan count does not fit in 16 bits
        if (s_q.scan_cnt == 17'(SCAN_CYCLES - 1))
        begin
            s_d.scan_cnt = 17'h0;
            s_d.scan_tick = 1'b1;
        end
        else
        begin
            s_d.scan_cnt = s_q.scan_cnt + 17'h1;
        end
        if (s_q.us_cnt == 8'(US_CYCLES - 1))
        begin
            s_d.us_cnt = 8'h0;
            s_d.time_us = s_q.time_us + 32'h1;
        end
        else
        begin
            s_d.us_cnt = s_q.us_cnt + 8'h1;
        end

        // ------------------------------------------------------------
        // protection pass timer and operand publication
        // ------------------------------------------------------------
        // software writes the pass length from tracked frequency / 8
        s_d.pass_start = 1'b0;
        if (s_q.pass_cnt >= s_q.pass_cycles - 32'h1)
        begin
            s_d.pass_cnt = 32'h0;
            s_d.pass_start = 1'b1;
        end
        else
        begin
            s_d.pass_cnt = s_q.pass_cnt + 32'h1;
        end
        // validated states wait for the next pass, bounding delay by one pass
        s_d.pending = lane_state;
        if (s_q.pass_start)
        begin
            s_d.closed_op = s_q.pending;
            s_d.open_op = ~s_q.pending;
        end

        // ------------------------------------------------------------
        // event records, lowest index wins when lanes change together
        // ------------------------------------------------------------
        // simultaneous changes beyond the first are dropped from the stream
        s_d.ev_valid = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++)
        begin
            if (!found && lane_change[i] && s_q.ev_enable[i])
            begin
                found = 1'b1;
                s_d.ev_valid = 1'b1;
                s_d.ev_index = 8'(i);
                s_d.ev_state = lane_state[i];
                s_d.ev_stamp = lane_stamp[i];
                s_d.last_stamp = lane_stamp[i];
            end
        end

        // ------------------------------------------------------------
        // axi4-lite write path
        // ------------------------------------------------------------
        s_d.awready = 1'b0;
        s_d.wready = 1'b0;
        if (s_axi_awvalid && !s_q.aw_held && !s_q.awready)
        begin
            s_d.awready = 1'b1;
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_held && !s_q.wready)
        begin
            s_d.wready = 1'b1;
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end
        for (int b = 0; b < 4; b++)
        begin
            wmerged[b*8 +: 8] = s_q.w_strb[b] ? s_q.w_data[b*8 +: 8] : 8'h00;
        end
        do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
        if (do_write)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = AXI_OKAY;
            if (s_q.aw_addr == REG_STATUS)
            begin
                s_d.status = s_q.status & ~wmerged[1:0];
            end
            else if (s_q.aw_addr == REG_MASK)
            begin
                s_d.mask = wmerged[1:0];
            end
            else if (s_q.aw_addr == REG_CONFIG)
            begin
                cur = {16'h0, s_q.ev_enable, 4'h0, s_q.debounce};
                for (int b = 0; b < 4; b++)
                begin
                    if (s_q.w_strb[b])
                    begin
                        cur[b*8 +: 8] = s_q.w_data[b*8 +: 8];
                    end
                end
                s_d.debounce = cur[CFG_DEBOUNCE_LSB +: 4];
                s_d.ev_enable = cur[CFG_ENABLE_LSB +: NUM_INPUTS];
            end
            else if (s_q.aw_addr == REG_THRESH)
            begin
                for (int b = 0; b < NUM_GROUPS; b++)
                begin
                    if (s_q.w_strb[b])
                    begin
                        s_d.thresh[b*8 +: 8] = s_q.w_data[b*8 +: 8];
                    end
                end
            end
            else if (s_q.aw_addr == REG_PASS)
            begin
                cur = s_q.pass_cycles;
                for (int b = 0; b < 4; b++)
                begin
                    if (s_q.w_strb[b])
                    begin
                        cur[b*8 +: 8] = s_q.w_data[b*8 +: 8];
                    end
                end
                s_d.pass_cycles = (cur == 32'h0) ? 32'h1 : cur;
            end
            else
            begin
                s_d.bresp = AXI_SLVERR;
            end
        end

        // hardware set beats the write-one clear
        if (s_q.ev_valid)
        begin
            s_d.status[ST_EVENT] = 1'b1;
        end
        if (s_q.pass_start)
        begin
            s_d.status[ST_PASS] = 1'b1;
        end
        s_d.irq = |(s_d.status & s_d.mask);

        // ------------------------------------------------------------
        // axi4-lite read path
        // ------------------------------------------------------------
        s_d.arready = 1'b0;
        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid && !s_q.arready)
        begin
            s_d.arready = 1'b1;
            s_d.rvalid = 1'b1;
            s_d.rresp = AXI_OKAY;
            s_d.rdata = 32'h0;
            if (s_axi_araddr == REG_STATUS)
            begin
                s_d.rdata = {30'h0, s_q.status};
            end
            else if (s_axi_araddr == REG_MASK)
            begin
                s_d.rdata = {30'h0, s_q.mask};
            end
            else if (s_axi_araddr == REG_LEVEL)
            begin
                s_d.rdata = {16'h0, 8'(closed_sample), s_q.closed_op};
            end
            else if (s_axi_araddr == REG_CONFIG)
            begin
                s_d.rdata = {16'h0, s_q.ev_enable, 4'h0, s_q.debounce};
            end
            else if (s_axi_araddr == REG_THRESH)
            begin
                s_d.rdata = 32'(s_q.thresh);
            end
            else if (s_axi_araddr == REG_PASS)
            begin
                s_d.rdata = s_q.pass_cycles;
            end
            else if (s_axi_araddr == REG_EVENT)
            begin
                s_d.rdata = {23'h0, s_q.ev_state, s_q.ev_index};
            end
            else if (s_axi_araddr == REG_STAMP)
            begin
                s_d.rdata = s_q.last_stamp;
            end
            else
            begin
                s_d.rresp = AXI_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            s_q <= '0;
            s_q.open_op <= '1;
            s_q.debounce <= DEFAULT_DEBOUNCE;
            s_q.thresh <= {NUM_GROUPS{DEFAULT_THRESHOLD}};
            s_q.pass_cycles <= DEFAULT_PASS_CYCLES;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pass_start_out = s_q.pass_start;
    assign input_closed_operand_out = s_q.closed_op;
    assign input_open_operand_out = s_q.open_op;
    assign event_valid_out = s_q.ev_valid;
    assign event_index_out = s_q.ev_index;
    assign event_state_out = s_q.ev_state;
    assign event_stamp_out = s_q.ev_stamp;
    assign irq_out = s_q.irq;
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
endmodule

// ---- tb/contact_input_debounce_asserts.sv ----
// port-level checks for the contact input debounce block
`timescale 1ns/1ps
module contact_input_checker
    import contact_input_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // protection pass side
    input wire logic pass_start_out,
    input wire logic [NUM_INPUTS-1:0] input_closed_operand_out,
    input wire logic [NUM_INPUTS-1:0] input_open_operand_out,
    // event records
    input wire logic event_valid_out,
    input wire logic [7:0] event_index_out,
    input wire logic event_state_out,
    input wire logic [31:0] event_stamp_out,
    // axi4-lite
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    // ------------------------------
    // operand and event checks
    // ------------------------------
    default clocking dclk @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_OPEN_COMPL: assert property (input_open_operand_out == ~input_closed_operand_out)
        else $error("open operand not complement of closed");
    AST_OP_AT_PASS: assert property ($changed(input_closed_operand_out) |-> $past(pass_start_out))
        else $error("operand moved outside pass start");
    AST_EVENT_PULSE: assert property (event_valid_out |=> !event_valid_out)
        else $error("event record longer than one cycle");
    AST_STAMP_HOLD: assert property ($changed(event_stamp_out) |-> event_valid_out)
        else $error("stamp changed without a record");
    // slow passes would break this bound; the bench keeps passes short
    AST_EVENT_OPERAND: assert property (event_valid_out |-> ##[1:1000]
        (input_closed_operand_out[event_index_out[2:0]] == event_state_out))
        else $error("operand did not follow the record");
    // ------------------------------
    // register bus checks
    // ------------------------------
    AST_AW_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_wready && !s_axi_bvalid |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid)
        else $error("write not answered on time");
    AST_AR_ANSWER: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready && s_axi_rvalid)
        else $error("read not answered on time");
    AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    AST_RD_ERR: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");

    cover property (event_valid_out && event_state_out);
    cover property (event_valid_out && !event_state_out);
    cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule

bind contact_input_debounce contact_input_checker chk_u (
    .ref_clk_in, .reset_n_in, .pass_start_out, .input_closed_operand_out,
    .input_open_operand_out, .event_valid_out, .event_index_out, .event_state_out,
    .event_stamp_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp
);

// ---- tb/field_model.sv ----
// field contacts and protection engine facing the debounce block
`timescale 1ns/1ps
module field_model
    import contact_input_pkg::*;
(
    // clock
    input wire logic ref_clk_in,
    // protection engine side
    input wire logic pass_start_in,
    // sensed contact voltage codes
    output logic [NUM_INPUTS*8-1:0] level_out
);
    // ------------------------------
    // field sources and engine
    // ------------------------------
    // a 24 V wet source lands right on the advised threshold
    localparam logic [7:0] SRC24_CODE = 8'h11;
    logic [7:0] code_q [NUM_INPUTS];
    int cnt = 0;
    int gap = 0;

    initial
    begin
        foreach (code_q[i])
            code_q[i] = 8'h00;
    end

    always_comb
    begin
        for (int i = 0; i < NUM_INPUTS; i++)
            level_out[8*i +: 8] = code_q[i];
    end

    task automatic set_code(input int i, input logic [7:0] c);
        @(posedge ref_clk_in);
        code_q[i] <= c;
    endtask

    // engine clocks its pass length between pass starts
    always @(posedge ref_clk_in)
    begin
        cnt <= pass_start_in ? 0 : cnt + 1;
        if (pass_start_in)
            gap <= cnt + 1;
    end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the contact input debounce block
`timescale 1ns/1ps
module tb_top
    import contact_input_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [NUM_INPUTS*8-1:0] level_in;
    logic pass_start_out, event_valid_out, event_state_out, irq_out;
    logic [NUM_INPUTS-1:0] input_closed_operand_out, input_open_operand_out;
    logic [7:0] event_index_out;
    logic [31:0] event_stamp_out, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    int n_fail = 0, total_checks = 0, n_ev = 0;
    realtime t_rel = 0;

    field_model field_u (.ref_clk_in, .pass_start_in(pass_start_out), .level_out(level_in));
    contact_input_debounce dut_u (.ref_clk_in, .reset_n_in, .level_in, .pass_start_out,
        .input_closed_operand_out, .input_open_operand_out, .event_valid_out,
        .event_index_out, .event_state_out, .event_stamp_out, .irq_out, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp);

    always #2.5 ref_clk_in = ~ref_clk_in;

    always @(posedge ref_clk_in)
        if (event_valid_out) n_ev <= n_ev + 1;

    // ------------------------------
    // compare and bus tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    function automatic int us_now();
        return int'(($realtime - t_rel) / 1000.0);
    endfunction

    // write address and data offered together, each released once taken
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge ref_clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge ref_clk_in);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(e));
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge ref_clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk_in); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge ref_clk_in);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk(32'(s_axi_rresp), 32'(e));
    endtask

    task automatic wait_ev();
        for (int k = 0; k < 300000 && !event_valid_out; k++) @(posedge ref_clk_in);
        // a wait that runs out counts as a mismatch
        chk(32'(event_valid_out), 32'h1);
    endtask

    task automatic wait_op(input logic [7:0] from, output int k);
        for (k = 0; k < 1000 && input_closed_operand_out === from; k++) @(posedge ref_clk_in);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------
    // tests
    // ------------------------------
    initial
    begin
        int k;
        int u;
        int c;
        repeat (8) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        t_rel = $realtime;
        chk(32'(input_closed_operand_out), 32'h00);
        chk(32'(input_open_operand_out), 32'hFF);
        rchk(REG_CONFIG, 32'h00000005, AXI_OKAY);
        rchk(REG_THRESH, 32'h00001111, AXI_OKAY);
        rchk(REG_PASS, DEFAULT_PASS_CYCLES, AXI_OKAY);
        rchk(8'h20, 32'h0, AXI_SLVERR);
        wchk(REG_LEVEL, 32'h0, AXI_SLVERR);
        wchk(REG_PASS, 32'h0, AXI_OKAY);
        rchk(REG_PASS, 32'h1, AXI_OKAY);
        wchk(REG_PASS, 32'h000000C8, AXI_OKAY);
        repeat (401) @(posedge ref_clk_in);
        chk(32'(field_u.gap), 32'd200);
        wchk(REG_THRESH, 32'h00001140, AXI_OKAY);
        // debounce of one scan, events on input 4 only
        wchk(REG_CONFIG, 32'h00001001, AXI_OKAY);
        $display("test registers done");

        field_u.set_code(0, 8'h40);
        field_u.set_code(1, 8'h3F);
        field_u.set_code(4, field_u.SRC24_CODE);
        field_u.set_code(5, 8'h10);
        u = us_now();
        wait_ev();
        chk(32'(event_index_out), 32'h04);
        chk(32'(event_state_out), 32'h1);
        chk_rng(32'(us_now() - u), 500, 1001);
        chk_rng(event_stamp_out, us_now() - 503, us_now() - 497);
        wait_op(8'h00, k);
        chk(32'(input_closed_operand_out), 32'h11);
        chk_rng(32'(k), 0, 203);
        chk(32'(input_open_operand_out), 32'hEE);
        chk(32'(irq_out), 32'h0);
        rchk(REG_STATUS, 32'h00000003, AXI_OKAY);
        rchk(REG_EVENT, 32'h00000104, AXI_OKAY);
        wchk(REG_MASK, 32'h1, AXI_OKAY);
        repeat (2) @(posedge ref_clk_in);
        chk(32'(irq_out), 32'h1);
        wchk(REG_STATUS, 32'h1, AXI_OKAY);
        repeat (2) @(posedge ref_clk_in);
        chk(32'(irq_out), 32'h0);
        $display("test close done");

        // short lows hold one scan at most, highs at least one
        c = n_ev;
        for (int g = 0; g < 4; g++)
        begin
            field_u.set_code(4, g[0] ? field_u.SRC24_CODE : 8'h00);
            repeat (g[0] ? 150000 : 99990) @(posedge ref_clk_in);
        end
        chk(32'(n_ev), 32'(c));
        $display("test bounce done");

        field_u.set_code(4, 8'h00);
        u = us_now();
        wait_ev();
        chk(32'(event_state_out), 32'h0);
        chk_rng(32'(us_now() - u), 500, 1001);
        chk_rng(event_stamp_out, us_now() - 503, us_now() - 497);
        wait_op(8'h11, k);
        chk(32'(input_closed_operand_out), 32'h01);
        chk(32'(input_open_operand_out), 32'hFE);
        $display("test open done");
        end_sim();
    end

    initial
    begin
        repeat (1500000) @(posedge ref_clk_in);
        n_fail++;
        end_sim();
    end
endmodule
